// ===== design/hwd_cmd_top.sv
// Command handler for output set, keep-alive and host watchdog commands.
// Assumes a UART delivering and taking ASCII bytes on clk, and an APB master.
//
// Chosen here: the APB register port and the register addresses.
`default_nettype none

module hwd_cmd_top #(
  parameter int TICK_CYCLES = hwd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic rxReady,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic [hwd_pkg::NUM_OUT-1:0] outputState,
  output logic irq
);

  hwd_pkg::hwd_core_t r, n;

  logic expired;
  logic kick, clrFlag, setOut, setVal, cfgWr, cfgEn, rejected, doReply, mapped;
  logic [2:0] setCh, repLen;
  logic [7:0] cfgTt, statusByte;
  logic [5:0][7:0] rep;

  assign statusByte = {r.wdEn, 4'h0, r.timeoutFlag, 2'b00};

  // ***************************************
  // Frame evaluation
  // ***************************************
  always_comb begin
    logic [3:0] bodyLen;
    logic [7:0] sum;
    logic [4:0] a1, a2, c1, c2, t1, t2;
    logic good, addrOk;
    bodyLen = r.rxLen - (r.chkEn ? 4'd2 : 4'd0);
    sum = 8'h00;
    for (int i = 0; i < hwd_pkg::BUF_LEN; i++) begin
      if (4'(i) < bodyLen) sum = sum + r.rxBuf[i];
    end
    c1 = hwd_pkg::hex_val(r.rxBuf[bodyLen]);
    c2 = hwd_pkg::hex_val(r.rxBuf[4'(bodyLen + 4'd1)]);
    a1 = hwd_pkg::hex_val(r.rxBuf[1]);
    a2 = hwd_pkg::hex_val(r.rxBuf[2]);
    t1 = hwd_pkg::hex_val(r.rxBuf[5]);
    t2 = hwd_pkg::hex_val(r.rxBuf[6]);
    addrOk = a1[4] && a2[4] && {a1[3:0], a2[3:0]} == r.moduleAddressField;
    // A bad checksum counts as a corrupted frame and is dropped
    good = !r.rxOvf && r.rxLen >= (r.chkEn ? 4'd5 : 4'd3) &&
           (!r.chkEn || (c1[4] && c2[4] && {c1[3:0], c2[3:0]} == sum));
    kick = 1'b0;
    clrFlag = 1'b0;
    setOut = 1'b0;
    setCh = 3'd0;
    setVal = 1'b0;
    cfgWr = 1'b0;
    cfgEn = 1'b0;
    cfgTt = 8'h00;
    rejected = 1'b0;
    doReply = 1'b0;
    rep = '0;
    repLen = 3'd0;
    // Only the end character commits a frame; a prefix of a longer frame must not act
    if (good && r.st == hwd_pkg::ST_RX && rxValid && rxData == hwd_pkg::CH_CR) begin
      if (r.rxBuf[0] == hwd_pkg::CH_TILDE && r.rxBuf[1] == hwd_pkg::CH_STAR &&
          r.rxBuf[2] == hwd_pkg::CH_STAR && bodyLen == 4'd3) begin
        kick = 1'b1;
      end else if (addrOk && r.rxBuf[0] == hwd_pkg::CH_HASH && bodyLen == 4'd7) begin
        doReply = 1'b1;
        repLen = 3'd1;
        if (r.timeoutFlag) begin
          rep[0] = hwd_pkg::CH_EXCL;
        end else if ((r.rxBuf[3] == hwd_pkg::CH_1 || r.rxBuf[3] == hwd_pkg::CH_A) &&
                     r.rxBuf[4] >= hwd_pkg::CH_0 && r.rxBuf[4] <= hwd_pkg::CH_4 &&
                     r.rxBuf[5] == hwd_pkg::CH_0 &&
                     (r.rxBuf[6] == hwd_pkg::CH_0 || r.rxBuf[6] == hwd_pkg::CH_1)) begin
          setOut = 1'b1;
          setCh = 3'(r.rxBuf[4] - hwd_pkg::CH_0);
          setVal = r.rxBuf[6][0];
          rep[0] = hwd_pkg::CH_GT;
        end else begin
          rep[0] = hwd_pkg::CH_QM;
          rejected = 1'b1;
        end
      end else if (addrOk && r.rxBuf[0] == hwd_pkg::CH_TILDE &&
                   (bodyLen == 4'd4 || (bodyLen == 4'd7 && r.rxBuf[3] == hwd_pkg::CH_3))) begin
        doReply = 1'b1;
        rep[0] = hwd_pkg::CH_EXCL;
        rep[1] = r.rxBuf[1];
        rep[2] = r.rxBuf[2];
        repLen = 3'd3;
        if (bodyLen == 4'd7) begin
          if ((r.rxBuf[4] == hwd_pkg::CH_0 || r.rxBuf[4] == hwd_pkg::CH_1) &&
              t1[4] && t2[4]) begin
            cfgWr = 1'b1;
            cfgEn = r.rxBuf[4][0];
            cfgTt = {t1[3:0], t2[3:0]};
            rep[3] = r.rxBuf[4];
            rep[4] = hwd_pkg::hex_char(t1[3:0]);
            rep[5] = hwd_pkg::hex_char(t2[3:0]);
            repLen = 3'd6;
          end else begin
            rep[0] = hwd_pkg::CH_QM;
            rejected = 1'b1;
          end
        end else begin
          case (r.rxBuf[3])
            hwd_pkg::CH_0: begin
              rep[3] = hwd_pkg::hex_char(statusByte[7:4]);
              rep[4] = hwd_pkg::hex_char(statusByte[3:0]);
              repLen = 3'd5;
            end
            hwd_pkg::CH_1: begin
              clrFlag = 1'b1;
            end
            8'h32: begin
              rep[3] = r.wdEn ? hwd_pkg::CH_1 : hwd_pkg::CH_0;
              rep[4] = hwd_pkg::hex_char(r.timeoutValueField[7:4]);
              rep[5] = hwd_pkg::hex_char(r.timeoutValueField[3:0]);
              repLen = 3'd6;
            end
            default: begin
              rep[0] = hwd_pkg::CH_QM;
              rejected = 1'b1;
            end
          endcase
        end
      end
    end
  end

  hwd_wdog_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    // Timer sees the values that stand after this edge, so a frame's new timeout loads at once; an APB one, while enabled, at the next reload
    .enable(n.wdEn),
    .reload(kick || clrFlag || cfgWr || !r.wdEn),
    .timeoutValue(n.timeoutValueField),
    .expired(expired)
  );

  // ***************************************
  // APB decode
  // ***************************************
  always_comb begin
    if (paddr == hwd_pkg::OFF_CTRL) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_WDCFG) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_STATUS) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_SAFE) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_IRQ_STAT) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_IRQ_CLR) mapped = 1'b1;
    else if (paddr == hwd_pkg::OFF_IRQ_EN) mapped = 1'b1;
    else mapped = 1'b0;
  end

  // ***************************************
  // Next state
  // ***************************************
  always_comb begin
    logic [7:0] sumNew;
    logic wrAcc;
    n = r;
    sumNew = r.txSum + r.txData;
    wrAcc = psel && penable && pwrite;
    // Read data is captured in setup so that it comes from a flop in access
    if (psel && !penable) begin
      if (paddr == hwd_pkg::OFF_CTRL) begin
        n.prdata = '0;
        n.prdata[hwd_pkg::CTRL_CHK_BIT] = r.chkEn;
        n.prdata[hwd_pkg::CTRL_ADDR_LSB +: 8] = r.moduleAddressField;
      end else if (paddr == hwd_pkg::OFF_WDCFG) begin
        n.prdata = '0;
        n.prdata[hwd_pkg::WDCFG_EN_BIT] = r.wdEn;
        n.prdata[hwd_pkg::WDCFG_TT_LSB +: 8] = r.timeoutValueField;
      end else if (paddr == hwd_pkg::OFF_STATUS) begin
        n.prdata = {19'h0, r.outputValueField, statusByte};
      end else if (paddr == hwd_pkg::OFF_SAFE) begin
        n.prdata = {27'h0, r.safeVal};
      end else if (paddr == hwd_pkg::OFF_IRQ_STAT) begin
        n.prdata = {28'h0, r.irqStat};
      end else if (paddr == hwd_pkg::OFF_IRQ_EN) begin
        n.prdata = {28'h0, r.irqEn};
      end else begin
        n.prdata = '0;
      end
    end
    if (wrAcc) begin
      if (paddr == hwd_pkg::OFF_CTRL) begin
        n.chkEn = pwdata[hwd_pkg::CTRL_CHK_BIT];
        n.moduleAddressField = pwdata[hwd_pkg::CTRL_ADDR_LSB +: 8];
      end else if (paddr == hwd_pkg::OFF_WDCFG) begin
        n.wdEn = pwdata[hwd_pkg::WDCFG_EN_BIT];
        n.timeoutValueField = pwdata[hwd_pkg::WDCFG_TT_LSB +: 8];
      end else if (paddr == hwd_pkg::OFF_SAFE) begin
        n.safeVal = pwdata[4:0];
      end else if (paddr == hwd_pkg::OFF_IRQ_CLR) begin
        n.irqStat = r.irqStat & ~pwdata[3:0];
      end else if (paddr == hwd_pkg::OFF_IRQ_EN) begin
        n.irqEn = pwdata[3:0];
      end
    end

    // Command effects follow the bus so a frame wins a same-cycle write
    if (cfgWr) begin
      n.wdEn = cfgEn;
      n.timeoutValueField = cfgTt;
    end
    if (setOut) n.outputValueField[setCh] = setVal;
    if (clrFlag) n.timeoutFlag = 1'b0;
    if (expired) begin
      n.timeoutFlag = 1'b1;
      n.outputValueField = r.safeVal;
    end
    // Events set after the clear so a same-cycle event is kept
    if (expired) n.irqStat[hwd_pkg::IRQ_TIMEOUT] = 1'b1;
    if (setOut) n.irqStat[hwd_pkg::IRQ_OUTSET] = 1'b1;
    if (rejected) n.irqStat[hwd_pkg::IRQ_REJECT] = 1'b1;
    if (kick) n.irqStat[hwd_pkg::IRQ_KICK] = 1'b1;

    // ***************************************
    // Receive and reply sequencer
    // ***************************************
    case (r.st)
      hwd_pkg::ST_RX: begin
        if (rxValid) begin
          if (rxData == hwd_pkg::CH_CR) begin
            n.rxLen = 4'd0;
            n.rxOvf = 1'b0;
            if (doReply) begin
              n.txBuf = rep;
              n.txLen = repLen;
              n.txIdx = 3'd1;
              n.txSum = 8'h00;
              n.txData = rep[0];
              n.st = hwd_pkg::ST_BODY;
            end
          end else if (rxData != hwd_pkg::CH_LF) begin
            // Overlong frames are marked and later dropped silently
            if (r.rxLen == 4'(hwd_pkg::BUF_LEN)) begin
              n.rxOvf = 1'b1;
            end else begin
              n.rxBuf[r.rxLen] = rxData;
              n.rxLen = r.rxLen + 4'd1;
            end
          end
        end
      end
      hwd_pkg::ST_BODY: begin
        if (txReady) begin
          n.txSum = sumNew;
          if (r.txIdx == r.txLen) begin
            n.st = r.chkEn ? hwd_pkg::ST_CHK_HI : hwd_pkg::ST_END;
            n.txData = r.chkEn ? hwd_pkg::hex_char(sumNew[7:4]) : hwd_pkg::CH_CR;
          end else begin
            n.txData = r.txBuf[r.txIdx];
            n.txIdx = r.txIdx + 3'd1;
          end
        end
      end
      hwd_pkg::ST_CHK_HI: begin
        if (txReady) begin
          n.txData = hwd_pkg::hex_char(r.txSum[3:0]);
          n.st = hwd_pkg::ST_CHK_LO;
        end
      end
      hwd_pkg::ST_CHK_LO: begin
        if (txReady) begin
          n.txData = hwd_pkg::CH_CR;
          n.st = hwd_pkg::ST_END;
        end
      end
      hwd_pkg::ST_END: begin
        if (txReady) n.st = hwd_pkg::ST_RX;
      end
      default: n.st = hwd_pkg::ST_RX;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.chkEn <= hwd_pkg::RST_CHK;
      r.moduleAddressField <= hwd_pkg::RST_ADDR;
      r.wdEn <= hwd_pkg::RST_WDEN;
      r.timeoutValueField <= hwd_pkg::RST_TT;
      r.outputValueField <= hwd_pkg::RST_OUT;
      r.safeVal <= hwd_pkg::RST_SAFE;
    end else begin
      r <= n;
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign rxReady = (r.st == hwd_pkg::ST_RX);
  assign txValid = (r.st != hwd_pkg::ST_RX);
  assign txData = r.txData;
  assign outputState = r.outputValueField;
  assign irq = |(r.irqStat & r.irqEn);

endmodule

`default_nettype wire

// ===== design/hwd_pkg.sv
// Constants, types and ASCII helpers shared by the host watchdog command block.
// Assumes byte-wide character streams from a UART on the same 100 MHz clock.
`default_nettype none

package hwd_pkg;

  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // ***************************************
  // Sizes
  // ***************************************
  localparam int BUF_LEN = 12;
  localparam int NUM_OUT = 5;

  // ***************************************
  // APB map, fields and reset values
  // ***************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_WDCFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SAFE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam int CTRL_CHK_BIT = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int WDCFG_EN_BIT = 0;
  localparam int WDCFG_TT_LSB = 8;
  localparam int STAT_OUT_LSB = 8;
  localparam int STS_TIMEOUT_BIT = 2;
  localparam int STS_EN_BIT = 7;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_OUTSET = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_KICK = 3;
  localparam int IRQ_W = 4;
  localparam logic RST_CHK = 1'b0;
  localparam logic [7:0] RST_ADDR = 8'h01;
  localparam logic RST_WDEN = 1'b0;
  localparam logic [7:0] RST_TT = 8'h00;
  localparam logic [4:0] RST_OUT = 5'h00;
  localparam logic [4:0] RST_SAFE = 5'h00;

  // ***************************************
  // Characters
  // ***************************************
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_TILDE = 8'h7E;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_GT = 8'h3E;
  localparam logic [7:0] CH_QM = 8'h3F;
  localparam logic [7:0] CH_EXCL = 8'h21;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_4 = 8'h34;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_LA = 8'h61;

  typedef enum logic [2:0] {ST_RX, ST_BODY, ST_CHK_HI, ST_CHK_LO, ST_END} hwd_state_t;

  typedef struct packed {
    hwd_state_t st;
    logic [BUF_LEN-1:0][7:0] rxBuf;
    logic [3:0] rxLen;
    logic rxOvf;
    logic [5:0][7:0] txBuf;
    logic [2:0] txLen;
    logic [2:0] txIdx;
    logic [7:0] txSum;
    logic [7:0] txData;
    logic chkEn;
    logic [7:0] moduleAddressField;
    logic wdEn;
    logic [7:0] timeoutValueField;
    logic timeoutFlag;
    logic [NUM_OUT-1:0] outputValueField;
    logic [NUM_OUT-1:0] safeVal;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    logic [31:0] prdata;
  } hwd_core_t;

  // Returns {valid, nibble}; both letter cases accepted
  function automatic logic [4:0] hex_val(logic [7:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c >= CH_0 && c <= 8'h39) v = {1'b1, 4'(c - CH_0)};
    else if (c >= CH_A && c <= 8'h46) v = {1'b1, 4'(c - CH_A + 8'h0A)};
    else if (c >= CH_LA && c <= 8'h66) v = {1'b1, 4'(c - CH_LA + 8'h0A)};
    return v;
  endfunction

  function automatic logic [7:0] hex_char(logic [3:0] n);
    return (n < 4'hA) ? 8'(CH_0 + 8'(n)) : 8'(CH_A + 8'(n) - 8'h0A);
  endfunction

endpackage

`default_nettype wire

// ===== design/hwd_wdog_timer.sv
// Host watchdog down-counter in 0.1 s steps.
// Assumes reload is a one-cycle pulse on the same clock.
`default_nettype none

module hwd_wdog_timer #(
  parameter int TICK_CYCLES = hwd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic reload,
  input wire logic [7:0] timeoutValue,
  output logic expired
);

  typedef struct packed {
    logic [31:0] pre;
    logic [7:0] count;
    logic fired;
    logic expired;
  } hwd_tmr_t;

  hwd_tmr_t r, n;

  always_comb begin
    n = r;
    n.expired = 1'b0;
    if (!enable || reload) begin
      n.pre = '0;
      n.count = timeoutValue;
      n.fired = 1'b0;
    end else if (r.count == 8'h00) begin
      // One pulse per expiry; the next needs a reload
      n.expired = !r.fired;
      n.fired = 1'b1;
    end else if (r.pre == 32'(TICK_CYCLES - 1)) begin
      n.pre = '0;
      n.count = r.count - 8'h01;
    end else begin
      n.pre = r.pre + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign expired = r.expired;

endmodule

`default_nettype wire

// ===== tb/hwd_cmd_assertions.sv
// Port checker for the host watchdog command block.
// Assumes it is bound to hwd_cmd_top and shares its clock and reset.
`default_nettype none

module hwd_cmd_assertions #(
  parameter int TICK_CYCLES = hwd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [hwd_pkg::NUM_OUT-1:0] outputState,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ****************
  // Link replies
  // ****************
  chk_reply_cause: assert property ($rose(txValid) |->
    $past(rxValid && rxReady && rxData == hwd_pkg::CH_CR))
    else $error("reply started without a frame end");
  chk_rx_blocked: assert property (txValid |-> !rxReady)
    else $error("receiver open while replying");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply character dropped under stall");
  chk_reply_stop: assert property (txValid && txReady && txData == hwd_pkg::CH_CR
    |=> !txValid)
    else $error("reply continues after end character");
  chk_reply_kind: assert property ($rose(txValid) |->
    txData inside {8'h3E, 8'h3F, 8'h21})
    else $error("reply starts with a wrong delimiter");
  chk_ka_silent: assert property (rxValid && rxReady && rxData == hwd_pkg::CH_TILDE
    ##1 rxValid && rxData == hwd_pkg::CH_STAR ##1 rxValid && rxData == hwd_pkg::CH_STAR
    ##1 rxValid && rxData == hwd_pkg::CH_CR |=> !txValid [*3])
    else $error("keep-alive answered");
  chk_reject_outs: assert property ($rose(txValid) && txData != hwd_pkg::CH_GT |->
    $stable(outputState))
    else $error("outputs moved on a refused command");

  // ****************
  // Register bus
  // ****************
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase not completed");
  chk_apb_err: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18}))
    else $error("slave error does not match the map");

  cov_keep_alive: cover property (rxValid && rxReady && rxData == hwd_pkg::CH_TILDE);
  cov_stall: cover property (txValid && !txReady);
  cov_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

// ===== tb/hwd_host_model.sv
// Host controller model on the byte link of the command block.
// Assumes one shared clock; the bench sends one frame at a time.
`default_nettype none

module hwd_host_model (
  input wire logic clk,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  bit slow = 1'b0;
  logic [95:0] reply = 96'h0;

  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b1;
  end

  // Stalls every other cycle in slow mode, as a busy UART would
  always @(posedge clk) begin
    txReady <= slow ? ~txReady : 1'b1;
    if (txValid && txReady) reply <= {reply[87:0], txData};
  end

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  task automatic put(input logic [7:0] c);
    rxValid <= 1'b1;
    rxData <= c;
    @(posedge clk);
    while (rxReady !== 1'b1) @(posedge clk);
  endtask

  task automatic send(input string s, input bit withSum);
    logic [7:0] sum;
    sum = 8'h00;
    reply = 96'h0;
    @(posedge clk);
    foreach (s[i]) begin
      put(s[i]);
      sum += s[i];
    end
    if (withSum) begin
      put(hexc(sum[7:4]));
      put(hexc(sum[3:0]));
    end
    put(hwd_pkg::CH_CR);
    rxValid <= 1'b0;
    // Released line shows the inverse, never a stale end character
    rxData <= 8'hF2;
  endtask
endmodule

`default_nettype wire

// ===== tb/test_host_watchdog_output_commands.sv
// Self-checking bench for the host watchdog command block.
// Assumes the host model and the checker files are compiled first.
`default_nettype none

module test_host_watchdog_output_commands;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] rxData;
  logic rxValid;
  logic rxReady;
  logic [7:0] txData;
  logic txValid;
  logic txReady;
  logic [4:0] outputState;
  logic irq;
  logic [95:0] rd;
  bit sumOn = 1'b0;
  int failCount = 0;
  int numChecks = 0;

  always #5 clk = ~clk;

  hwd_cmd_top #(.TICK_CYCLES(TICK)) hwd_cmd_top_inst (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .outputState(outputState), .irq(irq));

  hwd_host_model hwd_host_model_inst (
    .clk(clk), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady));

  // ****************
  // Tasks
  // ****************
  task automatic completeRun;
    $display("Comparisons %0d, mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // Slave error lands in bit 32 of the captured word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = 96'({pslverr, prdata});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [95:0] rep(input string s);
    logic [95:0] v;
    logic [7:0] sum;
    v = 96'h0;
    sum = 8'h00;
    if (s.len() == 0) return v;
    foreach (s[i]) begin
      v = {v[87:0], s[i]};
      sum += s[i];
    end
    if (sumOn)
      v = {v[79:0], hwd_host_model_inst.hexc(sum[7:4]), hwd_host_model_inst.hexc(sum[3:0])};
    return {v[87:0], hwd_pkg::CH_CR};
  endfunction

  // A silent frame costs the full bounded wait
  task automatic cmd(input string f, input string exp);
    hwd_host_model_inst.send(f, sumOn);
    for (int n = 0; n < 60 && hwd_host_model_inst.reply[7:0] !== hwd_pkg::CH_CR; n++)
      @(posedge clk);
    @(posedge clk);
    check(hwd_host_model_inst.reply, rep(exp));
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, hwd_pkg::OFF_CTRL, 32'h0);
    check(rd, 96'h100);
    apb(1'b0, hwd_pkg::OFF_WDCFG, 32'h0);
    check(rd, 96'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 96'h1_0000_0000);
    apb(1'b1, hwd_pkg::OFF_IRQ_EN, 32'h1);
    apb(1'b1, hwd_pkg::OFF_SAFE, 32'h11);
    cmd("#011201", ">");
    cmd("#01A401", ">");
    check(96'(outputState), 96'h14);
    cmd("#011501", "?");
    cmd("#011202", "?");
    cmd("#01B201", "?");
    cmd("#021201", "");
    cmd("#01120", "");
    cmd("~015", "?01");
    check(96'({irq, outputState}), 96'h14);
    cmd("~010", "!0100");
    cmd("~013105", "!01105");
    cmd("~012", "!01105");
    repeat (6) begin
      hwd_host_model_inst.send("~**", 1'b0);
      repeat (20) @(posedge clk);
    end
    check(96'(irq), 96'h0);
    repeat (70) @(posedge clk);
    check(96'({irq, outputState}), 96'h31);
    cmd("#011101", "!");
    check(96'(outputState), 96'h11);
    cmd("~010", "!0184");
    apb(1'b0, hwd_pkg::OFF_STATUS, 32'h0);
    check(rd, 96'h1184);
    apb(1'b0, hwd_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd, 96'hF);
    cmd("~013005", "!01005");
    apb(1'b1, hwd_pkg::OFF_IRQ_CLR, 32'h1);
    @(negedge clk);
    check(96'(irq), 96'h0);
    cmd("~011", "!01");
    cmd("~010", "!0100");
    cmd("#011101", ">");
    check(96'(outputState), 96'h13);
    apb(1'b1, hwd_pkg::OFF_CTRL, 32'hFF01);
    sumOn = 1'b1;
    hwd_host_model_inst.slow = 1'b1;
    cmd("#FF1401", ">");
    cmd("~FF31FF", "!FF1FF");
    cmd("~FF2", "!FF1FF");
    sumOn = 1'b0;
    cmd("#FF1401", "");
    completeRun();
  end

  initial begin
    #200_000;
    failCount++;
    completeRun();
  end
endmodule

bind hwd_cmd_top hwd_cmd_assertions #(.TICK_CYCLES(TICK_CYCLES)) hwd_cmd_assertions_inst (
  .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .rxData(rxData), .rxValid(rxValid),
  .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
  .outputState(outputState), .irq(irq));

`default_nettype wire
